// ==== src/bdcld_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none

module bdcld_decoder (
    // Complemented digit from the holding latch.
    input  wire logic [3:0]                 i_comp,
    // One line per decimal digit.
    output logic      [bdcld_pkg::DEC_N-1:0] o_dec
);
    import bdcld_pkg::*;

    // Each gate matches one complemented code; codes ten to fifteen match none.
    generate
        for (genvar k = 0; k < DEC_N; k++) begin : g_digit
            localparam logic [3:0] CODE = 4'(k);
            assign o_dec[k] = (i_comp == ~CODE);
        end
    endgenerate

endmodule // bdcld_decoder

`default_nettype wire

// ==== src/bdcld_pkg.sv ====
`default_nettype none

package bdcld_pkg;

    // APB address and data widths.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_CARRY  = 12'h008;

    // Control register fields.
    localparam int CTRL_BLANK = 0;
    localparam int CTRL_GATE  = 1;
    localparam int CTRL_CLEAR = 2;
    localparam int CTRL_XFER  = 3;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Status register fields.
    localparam int ST_CNT_LSB  = 0;
    localparam int ST_HOLD_LSB = 4;
    localparam int ST_BLANK    = 8;
    localparam int ST_LOAD     = 9;

    // Carry counter width and reset value.
    localparam int CARRY_W = 16;
    localparam logic [CARRY_W-1:0] CARRY_RST = 16'h0000;
    localparam logic [CARRY_W-1:0] CARRY_ONE = 16'h0001;

    // Digit codes.
    localparam logic [3:0] BCD_ZERO   = 4'h0;
    localparam logic [3:0] BCD_ONE    = 4'h1;
    localparam logic [3:0] BCD_MAX    = 4'h9;
    localparam logic [3:0] COMP_ZERO  = 4'hF;
    localparam logic [3:0] COMP_BLANK = 4'h0;

    // Decoder width.
    localparam int DEC_N = 10;
    localparam logic [DEC_N-1:0] DEC_RST = 10'h000;

    // Pin synchroniser order and idle levels.
    localparam int PIN_N     = 5;
    localparam int PIN_COUNT = 0;
    localparam int PIN_CLEAR = 1;
    localparam int PIN_BLANK = 2;
    localparam int PIN_XFERN = 3;
    localparam int PIN_GATE  = 4;
    localparam logic [PIN_N-1:0] PIN_IDLE = 5'h08;

    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // APB request from the master.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } bdcld_apb_req_t;

    // APB answer to the master.
    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } bdcld_apb_rsp_t;

endpackage : bdcld_pkg

`default_nettype wire

// ==== src/bdcld_top.sv ====
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module bdcld_top (
    // Clock and reset.
    input  wire logic                     i_clk,
    input  wire logic                     i_srst,
    // APB slave.
    input  wire bdcld_pkg::bdcld_apb_req_t i_apb,
    output bdcld_pkg::bdcld_apb_rsp_t     o_apb,
    // Pins from the count gating logic.
    input  wire logic                     i_count,
    input  wire logic                     i_clear,
    input  wire logic                     i_blank,
    input  wire logic                     i_xfer_n,
    input  wire logic                     i_gate,
    // Counter outputs.
    output logic      [3:0]               o_cnt_comp,
    output logic                          o_carry,
    // Holding latch outputs.
    output logic      [3:0]               o_hold_comp,
    output logic      [3:0]               o_hold_true_n,
    // Decoder outputs to the readout.
    output logic      [9:0]               o_dec
);
    import bdcld_pkg::*;

    // Pin synchroniser.
    logic [PIN_N-1:0] pin_w;
    logic [PIN_N-1:0] sync1_r;
    logic [PIN_N-1:0] sync2_r;
    logic             count_d_r;

    // Counter state.
    logic [3:0]       cnt_r;
    logic [3:0]       cnt_nxt;
    logic [3:0]       cnt_comp_r;
    logic [3:0]       cnt_comp_nxt;
    logic             carry_r;
    logic             blank_r;

    // Latch state.
    logic [3:0]       hold_r;
    logic [3:0]       true_n_r;
    logic [DEC_N-1:0] dec_r;
    logic [DEC_N-1:0] dec_w;

    // Register state.
    logic [1:0]         ctrl_r;
    logic [CARRY_W-1:0] carry_cnt_r;
    logic [CARRY_W-1:0] carry_cnt_nxt;
    logic [DATA_W-1:0]  prdata_r;
    logic               pready_r;
    logic               pslverr_r;

    // Decoded controls.
    logic             count_rise_w;
    logic             wrap_w;
    logic             clear_w;
    logic             blank_ctl_w;
    logic             blank_nxt_w;
    logic             load_w;
    logic             gate_w;
    logic             acc_w;
    logic             first_w;
    logic             done_w;
    logic             wr_w;
    logic             hit_ctrl_w;
    logic             hit_status_w;
    logic             hit_carry_w;
    logic             hit_w;
    logic             soft_clear_w;
    logic             soft_xfer_w;
    logic             carry_clr_w;
    logic [DATA_W-1:0] rdata_w;
    logic [DATA_W-1:0] status_w;
    logic [DATA_W-1:0] ctrl_word_w;
    logic [DATA_W-1:0] carry_word_w;
    logic [DATA_W-1:0] prdata_nxt;
    logic              pslverr_nxt;
    logic              carry_nxt;
    logic [1:0]        ctrl_nxt;
    wire logic [3:0]   hold_nxt;
    wire logic [3:0]   true_n_nxt;

    // Pins cross into the clock domain through two flip-flops.
    assign pin_w = {i_gate, i_xfer_n, i_blank, i_clear, i_count};

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync1_r <= PIN_IDLE;
            sync2_r <= PIN_IDLE;
        end else begin
            sync1_r <= pin_w;
            sync2_r <= sync1_r;
        end
    end

    // The edge detector rests at the pin's idle level, so reset makes no count.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count_d_r <= PIN_IDLE[PIN_COUNT];
        end else begin
            count_d_r <= sync2_r[PIN_COUNT];
        end
    end

    // A count is the rising edge of the synchronised count pin.
    assign count_rise_w = sync2_r[PIN_COUNT] & ~count_d_r;

    // APB decode.
    assign acc_w        = i_apb.psel & i_apb.penable;
    assign first_w      = acc_w & ~pready_r;
    assign done_w       = acc_w & pready_r;
    assign wr_w         = done_w & i_apb.pwrite;
    assign hit_ctrl_w   = (i_apb.paddr == OFS_CTRL);
    assign hit_status_w = (i_apb.paddr == OFS_STATUS);
    assign hit_carry_w  = (i_apb.paddr == OFS_CARRY);
    assign hit_w        = hit_ctrl_w | hit_status_w | hit_carry_w;

    // Write-one strobes in the control register act once and are not stored.
    assign soft_clear_w = wr_w & hit_ctrl_w & i_apb.pwdata[CTRL_CLEAR];
    assign soft_xfer_w  = wr_w & hit_ctrl_w & i_apb.pwdata[CTRL_XFER];
    assign carry_clr_w  = wr_w & hit_carry_w;

    // Counter controls.
    assign clear_w     = sync2_r[PIN_CLEAR] | soft_clear_w;
    assign wrap_w      = count_rise_w & (cnt_r == BCD_MAX);
    assign blank_ctl_w = sync2_r[PIN_BLANK] | ctrl_r[CTRL_BLANK];
    assign gate_w      = sync2_r[PIN_GATE] | ctrl_r[CTRL_GATE];

    // Clear wins over a count; the tenth count wraps to zero.
    always_comb begin
        cnt_nxt = cnt_r;
        if (clear_w) begin
            cnt_nxt = BCD_ZERO;
        end else if (wrap_w) begin
            cnt_nxt = BCD_ZERO;
        end else if (count_rise_w) begin
            cnt_nxt = cnt_r + BCD_ONE;
        end
    end

    // Blanking needs the control high and the first stage at zero.
    assign blank_nxt_w = blank_ctl_w & ~cnt_nxt[0];

    // Blanked digits drive all complemented lines low, true code fifteen.
    assign cnt_comp_nxt = blank_nxt_w ? COMP_BLANK : ~cnt_nxt;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_r      <= BCD_ZERO;
            cnt_comp_r <= COMP_ZERO;
        end else begin
            cnt_r      <= cnt_nxt;
            cnt_comp_r <= cnt_comp_nxt;
        end
    end

    // A clear in the wrap cycle swallows the carry as well as the count.
    assign carry_nxt = wrap_w & ~clear_w;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            blank_r <= 1'b0;
            carry_r <= 1'b0;
        end else begin
            blank_r <= blank_nxt_w;
            carry_r <= carry_nxt;
        end
    end

    // Latch loads while transfer is low, from pin or software strobe.
    assign load_w = ~sync2_r[PIN_XFERN] | soft_xfer_w;

    // Each bit is set or reset on its own; true lines are active low and gated.
    generate
        for (genvar b = 0; b < 4; b++) begin : g_hold_bit
            assign hold_nxt[b]   = load_w ? cnt_comp_r[b] : hold_r[b];
            assign true_n_nxt[b] = ~(hold_r[b] & gate_w);
        end
    endgenerate

    // True lines leave reset inactive high, as the enable then reads low.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold_r   <= COMP_ZERO;
            true_n_r <= COMP_ZERO;
        end else begin
            hold_r   <= hold_nxt;
            true_n_r <= true_n_nxt;
        end
    end

    // One-of-ten decoder on the held complemented digit.
    bdcld_decoder u_dec (
        .i_comp (hold_r),
        .o_dec  (dec_w)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dec_r <= DEC_RST;
        end else begin
            dec_r <= dec_w;
        end
    end

    // Carry counter; a software clear in a carry cycle restarts the count at one.
    always_comb begin
        carry_cnt_nxt = carry_cnt_r;
        if (carry_r && carry_clr_w) begin
            carry_cnt_nxt = CARRY_ONE;
        end else if (carry_r) begin
            carry_cnt_nxt = carry_cnt_r + CARRY_ONE;
        end else if (carry_clr_w) begin
            carry_cnt_nxt = CARRY_RST;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            carry_cnt_r <= CARRY_RST;
        end else begin
            carry_cnt_r <= carry_cnt_nxt;
        end
    end

    // Control register keeps blanking and gate enables; strobe bits are not stored.
    assign ctrl_nxt = {i_apb.pwdata[CTRL_GATE], i_apb.pwdata[CTRL_BLANK]};

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_w && hit_ctrl_w) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Status word.
    always_comb begin
        status_w                          = RDATA_ZERO;
        status_w[ST_CNT_LSB +: 4]         = cnt_r;
        status_w[ST_HOLD_LSB +: 4]        = hold_r;
        status_w[ST_BLANK]                = blank_r;
        status_w[ST_LOAD]                 = ~sync2_r[PIN_XFERN];
    end

    // Control word shows only the stored enables; strobes read back as zero.
    always_comb begin
        ctrl_word_w             = RDATA_ZERO;
        ctrl_word_w[CTRL_BLANK] = ctrl_r[CTRL_BLANK];
        ctrl_word_w[CTRL_GATE]  = ctrl_r[CTRL_GATE];
    end

    assign carry_word_w = {{(DATA_W - CARRY_W){1'b0}}, carry_cnt_r};

    // Read multiplexer.
    assign rdata_w = hit_ctrl_w   ? ctrl_word_w :
                     hit_status_w ? status_w :
                     hit_carry_w  ? carry_word_w :
                     RDATA_ZERO;

    // Unmapped addresses answer with an error and zero data.
    assign pslverr_nxt = first_w & ~hit_w;
    assign prdata_nxt  = (first_w && !i_apb.pwrite) ? rdata_w : RDATA_ZERO;

    // Answer one cycle into the access phase.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= RDATA_ZERO;
        end else begin
            pready_r  <= first_w;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // Outputs come straight from flip-flops.
    assign o_apb.prdata  = prdata_r;
    assign o_apb.pready  = pready_r;
    assign o_apb.pslverr = pslverr_r;
    assign o_cnt_comp    = cnt_comp_r;
    assign o_carry       = carry_r;
    assign o_hold_comp   = hold_r;
    assign o_hold_true_n = true_n_r;
    assign o_dec         = dec_r;

endmodule // bdcld_top

`default_nettype wire

// ==== test/bdcld_gate_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module bdcld_gate_model (
    // Clock.
    input  wire logic i_clk,
    // Pins toward the digit.
    output var logic  o_count,
    output var logic  o_clear,
    output var logic  o_xfer_n,
    output var logic  o_blank,
    output var logic  o_gate
);
    initial begin
        o_count = 1'b0;
        o_clear = 1'b0;
        o_xfer_n = 1'b1;
        o_blank = 1'b0;
        o_gate = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic levels(input logic b, input logic g);
        o_blank <= b;
        o_gate <= g;
        hold(5);
    endtask

    // Clears the digit before each measurement.
    task automatic clear();
        o_clear <= 1'b1;
        hold(3);
        o_clear <= 1'b0;
        hold(3);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            o_count <= 1'b1;
            hold(3);
            o_count <= 1'b0;
            hold(3);
        end
    endtask

    // Copies the count only between measurements.
    task automatic transfer();
        o_xfer_n <= 1'b0;
        hold(3);
        o_xfer_n <= 1'b1;
        hold(5);
    endtask
endmodule // bdcld_gate_model

`default_nettype wire

// ==== test/bdcld_top_chk.sv ====
`timescale 1ns/1ns
`default_nettype none

module bdcld_top_chk (
    input wire logic                      i_clk,
    input wire logic                      i_srst,
    input wire bdcld_pkg::bdcld_apb_req_t i_apb,
    input wire logic                      i_xfer_n,
    input wire logic [3:0]                o_cnt_comp,
    input wire logic                      o_carry,
    input wire logic [3:0]                o_hold_comp,
    input wire logic [3:0]                o_hold_true_n,
    input wire logic [9:0]                o_dec
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_count_range: assert property (o_cnt_comp == 4'h0 || o_cnt_comp >= 4'h6)
        else $error("count left zero to nine");
    chk_count_step: assert property (!$past(i_srst) && $changed(o_cnt_comp)
        && o_cnt_comp != 4'h0 && $past(o_cnt_comp) != 4'h0
        |-> o_cnt_comp == $past(o_cnt_comp) - 4'h1 || o_cnt_comp == 4'hF)
        else $error("count step wrong");
    chk_carry_wrap: assert property (o_carry |-> $past(o_cnt_comp) == 4'h6
        && (o_cnt_comp == 4'hF || o_cnt_comp == 4'h0))
        else $error("carry without wrap");
    chk_carry_pulse: assert property (o_carry |=> !o_carry)
        else $error("carry too long");
    chk_reset_vals: assert property ($past(i_srst) |-> o_cnt_comp == 4'hF
        && o_hold_comp == 4'hF && !o_carry)
        else $error("reset values wrong");
    chk_latch_hold: assert property ((i_xfer_n && !i_apb.psel)[*4] |=> $stable(o_hold_comp))
        else $error("latch moved");
    chk_dec_onehot: assert property ($onehot0(o_dec))
        else $error("decoder lines not one hot");
    chk_dec_one: assert property (o_dec[1] |-> $past(o_hold_comp) == 4'hE)
        else $error("digit one wrong");
    chk_dec_blank: assert property ($past(o_hold_comp) == 4'h0 |-> o_dec == 10'h000)
        else $error("blank decoded");
    chk_dec_zero: assert property (!$past(i_srst) && $past(o_hold_comp) == 4'hF
        |-> o_dec == 10'h001)
        else $error("digit zero wrong");
    chk_true_gate: assert property (!$past(i_srst)
        |-> (~o_hold_true_n & ~$past(o_hold_comp)) == 4'h0)
        else $error("true output wrong");
endmodule // bdcld_top_chk

bind bdcld_top bdcld_top_chk i_bdcld_top_chk (.i_clk, .i_srst, .i_apb, .i_xfer_n, .o_cnt_comp,
    .o_carry, .o_hold_comp, .o_hold_true_n, .o_dec);

`default_nettype wire

// ==== test/bdcld_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module bdcld_top_tb;
    import bdcld_pkg::*;

    typedef struct packed {
        logic [4:0] pulses;
        logic       gate;
        logic [3:0] digit;
    } bdcld_row_t;

    localparam bdcld_row_t ROWS [6] = '{'{5'h00, 1'b1, 4'h0}, '{5'h01, 1'b1, 4'h1},
        '{5'h07, 1'b0, 4'h7}, '{5'h09, 1'b1, 4'h9}, '{5'h0A, 1'b1, 4'h0}, '{5'h0D, 1'b1, 4'h3}};

    logic           clk;
    logic           srst;
    bdcld_apb_req_t req;
    bdcld_apb_rsp_t rsp;
    wire logic      p_count, p_clear, p_blank, p_xfer_n, p_gate;
    logic [3:0]     cnt_comp, hold_comp, true_n;
    logic           carry;
    logic [9:0]     dec;
    logic [31:0]    rd;
    logic           err;
    int             failures;
    int             samples_checked;

    bdcld_top i_bdcld_top (.i_clk(clk), .i_srst(srst), .i_apb(req), .o_apb(rsp),
        .i_count(p_count), .i_clear(p_clear), .i_blank(p_blank), .i_xfer_n(p_xfer_n),
        .i_gate(p_gate), .o_cnt_comp(cnt_comp), .o_carry(carry), .o_hold_comp(hold_comp),
        .o_hold_true_n(true_n), .o_dec(dec));
    bdcld_gate_model i_bdcld_gate_model (.i_clk(clk), .o_count(p_count), .o_clear(p_clear),
        .o_xfer_n(p_xfer_n), .o_blank(p_blank), .o_gate(p_gate));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial begin
        srst = 1'b1;
        req = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        foreach (ROWS[k]) begin
            i_bdcld_gate_model.levels(1'b0, ROWS[k].gate);
            i_bdcld_gate_model.clear();
            apb(1'b1, OFS_CARRY, 32'h0000_0000);
            i_bdcld_gate_model.pulses(ROWS[k].pulses);
            i_bdcld_gate_model.transfer();
            check(hold_comp, 4'(~ROWS[k].digit));
            check(true_n, ROWS[k].gate ? ROWS[k].digit : 4'hF);
            check(dec, 32'h0000_0001 << ROWS[k].digit);
            apb(1'b0, OFS_CARRY, 32'h0000_0000);
            check(rd, (ROWS[k].pulses >= 5'h0A) ? 32'h0000_0001 : 32'h0000_0000);
        end
        i_bdcld_gate_model.pulses(2);
        check({hold_comp, cnt_comp}, 8'hCA);
        i_bdcld_gate_model.levels(1'b1, 1'b1);
        check(cnt_comp, 4'hA);
        i_bdcld_gate_model.pulses(1);
        check(cnt_comp, 4'h0);
        i_bdcld_gate_model.transfer();
        check({dec, true_n}, 14'h000F);
        i_bdcld_gate_model.levels(1'b0, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0006);
        apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_BLANK);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0106);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_CLEAR);
        apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_XFER);
        i_bdcld_gate_model.hold(4);
        check({hold_comp, cnt_comp, dec}, 18'h3_FC01);
        i_bdcld_gate_model.levels(1'b0, 1'b0);
        check(true_n, 32'h0000_000F);
        apb(1'b1, OFS_CTRL, 32'h0000_0001 << CTRL_GATE);
        i_bdcld_gate_model.hold(1);
        check(true_n, 32'h0000_0000);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0001 << CTRL_GATE);
        i_bdcld_gate_model.pulses(3);
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check({cnt_comp, hold_comp, carry}, 9'h1FE);
        check(true_n, 32'h0000_000F);
        finish_test();
    end
endmodule // bdcld_top_tb

`default_nettype wire
